// File: rtl/mode_ctrl_cfg.svh
// Timing and value constants for the operating-mode controller
`ifndef MODE_CTRL_CFG_SVH
`define MODE_CTRL_CFG_SVH

// ----------------------------------------
// Fault pulse and reset values
// ----------------------------------------
`define FAULT_LEN 2'h3
`define FAULT_CNT_ZERO 2'h0
`define FAULT_CNT_ONE 2'h1
`define BIT_CLR 1'b0
`define BIT_SET 1'b1

`endif

// File: rtl/mode_ctrl_pkg.sv
// Types shared by the operating-mode controller files
package mode_ctrl_pkg;

  // ----------------------------------------
  // Debug command kinds
  // ----------------------------------------
  typedef enum logic [2:0] {
    cmd_mem,
    cmd_mem_status,
    cmd_dbg_reg,
    cmd_background,
    cmd_cpu_reg,
    cmd_trace,
    cmd_go
  } cmd_kind_t;

  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    mode_run,
    mode_background,
    mode_trace,
    mode_wait,
    mode_stop
  } mode_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    cmd_kind_t kind;
  } dbg_cmd_t;

  typedef struct packed {
    logic done;
    logic accepted;
    logic low_power_err;
  } dbg_resp_t;

  typedef struct packed {
    logic instr_boundary;
    logic wait_exec;
    logic stop_exec;
    logic irq_req;
  } core_evt_t;

endpackage : mode_ctrl_pkg

// File: rtl/cmd_gate.sv
// Per-mode acceptance of background debug commands
module cmd_gate
  import mode_ctrl_pkg::*;
(
  // Mode and command
  input mode_t mode,
  input dbg_cmd_t cmd,
  // Decision
  output logic accept,
  output logic low_power_err,
  output logic access_ok
);

  // ----------------------------------------
  // Command classes
  // ----------------------------------------
  wire nonintrusive = (cmd.kind == cmd_mem) || (cmd.kind == cmd_mem_status) ||
                      (cmd.kind == cmd_dbg_reg) || (cmd.kind == cmd_background); // RULE3
  wire is_mem = (cmd.kind == cmd_mem) || (cmd.kind == cmd_mem_status);
  wire low_power = (mode == mode_wait) || (mode == mode_stop);
  wire runs = (mode == mode_run) || (mode == mode_trace);

  // ----------------------------------------
  // Gating
  // ----------------------------------------
  wire wait_ok = (cmd.kind == cmd_background) || (cmd.kind == cmd_mem_status); // RULE9
  wire stop_ok = (cmd.kind == cmd_mem_status);
  assign accept = cmd.valid && ((mode == mode_background) || // RULE4
                                (runs && nonintrusive) || // RULE2
                                ((mode == mode_wait) && wait_ok) ||
                                ((mode == mode_stop) && stop_ok));
  assign low_power_err = accept && low_power && (cmd.kind == cmd_mem_status); // RULE10
  assign access_ok = accept && is_mem && !low_power;

endmodule : cmd_gate

// File: rtl/mode_ctrl.sv
// Operating-mode controller with background debug command gating
// Operation
// (RULE1) Entering background mode suspends the processor and awaits debug commands.
// (RULE2) Non-intrusive commands are accepted in run mode and background mode.
// (RULE3) Non-intrusive: memory, memory with status, debug registers, enter background.
// (RULE4) Background-class commands execute only in background mode.
// (RULE5) Background class: processor register access, single-step trace, resume.
// (RULE6) Wait instruction gates the processor clock off.
// (RULE7) Entering wait clears the interrupt mask bit.
// (RULE8) Interrupt wakes wait mode and starts the stacking sequence.
// (RULE9) Wait mode accepts only enter-background and memory-with-status commands.
// (RULE10) Memory-with-status in stop or wait returns low-power error, no access.
// (RULE11) Enter-background command in wait wakes chip into background mode.
// (RULE12) Stop instruction enters one of two stop modes only when enabled.
// (RULE13) Stop mode halts every internal clock.
// (RULE14) Stop instruction with stop disabled raises a reset fault, no stop.
// (RULE15) Forced background from run takes effect at an instruction boundary.
module mode_ctrl
  import mode_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Core events
  input core_evt_t core_evt,
  // System options
  input wire logic stop_enable_bit,
  input wire logic stop_deep_sel,
  // Decoded commands from the background debug controller
  input dbg_cmd_t dbg_cmd,
  // Answer to the background debug controller
  output dbg_resp_t dbg_resp,
  // Core control
  output logic cpu_hold,
  output logic cpu_clk_en,
  output logic clocks_halted,
  output logic stop_deep,
  output logic imask_clear,
  output logic stack_start,
  output logic resume_pulse,
  output logic trace_step,
  // Access strobes
  output logic mem_access_en,
  output logic cpu_reg_access,
  output logic dbg_reg_access,
  // Fault
  output logic stop_fault_reset
);

  `include "mode_ctrl_cfg.svh"

  // ----------------------------------------
  // State
  // ----------------------------------------
  mode_t mode_ff, nxt_mode;
  logic bg_pend_ff;
  logic stop_deep_ff;
  logic imask_clear_ff, stack_start_ff, resume_ff, trace_ff;
  logic mem_acc_ff, cpu_reg_ff, dbg_reg_ff;
  logic [1:0] fault_cnt_ff, nxt_fault_cnt;
  dbg_resp_t resp_ff, nxt_resp;

  // ----------------------------------------
  // Command gating
  // ----------------------------------------
  logic cmd_accept, cmd_lp_err, cmd_access_ok;

  cmd_gate u_gate (
    .mode(mode_ff),
    .cmd(dbg_cmd),
    .accept(cmd_accept),
    .low_power_err(cmd_lp_err),
    .access_ok(cmd_access_ok)
  );

  wire take_bg = cmd_accept && (dbg_cmd.kind == cmd_background);
  wire take_go = cmd_accept && (dbg_cmd.kind == cmd_go);
  wire take_trace = cmd_accept && (dbg_cmd.kind == cmd_trace);
  wire take_cpu_reg = cmd_accept && (dbg_cmd.kind == cmd_cpu_reg);
  wire take_dbg_reg = cmd_accept && (dbg_cmd.kind == cmd_dbg_reg);

  // ----------------------------------------
  // Mode transitions
  // ----------------------------------------
  wire in_run = (mode_ff == mode_run);
  wire in_wait = (mode_ff == mode_wait);
  wire in_stop = (mode_ff == mode_stop);
  wire run_stop_ok = in_run && core_evt.stop_exec && stop_enable_bit; // RULE12
  wire run_stop_bad = in_run && core_evt.stop_exec && !stop_enable_bit; // RULE14
  wire run_wait = in_run && !core_evt.stop_exec && core_evt.wait_exec; // RULE6
  wire run_bg = in_run && !core_evt.stop_exec && !core_evt.wait_exec &&
                core_evt.instr_boundary && (bg_pend_ff || take_bg); // RULE15
  wire wait_bg = in_wait && take_bg; // RULE11
  wire irq_wake = (in_wait && !take_bg && core_evt.irq_req) || (in_stop && core_evt.irq_req); // RULE8
  wire trace_done = (mode_ff == mode_trace) && core_evt.instr_boundary;
  wire pend_set = take_bg && in_run && !run_bg;
  // Any entry into background consumes a pending request
  wire pend_clr = run_bg || wait_bg;

  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      mode_run: begin
        if (run_stop_ok) begin
          nxt_mode = mode_stop;
        end else if (run_wait) begin
          nxt_mode = mode_wait;
        end else if (run_bg) begin
          nxt_mode = mode_background; // RULE1
        end
      end
      mode_background: begin
        if (take_go) begin
          nxt_mode = mode_run; // RULE5
        end else if (take_trace) begin
          nxt_mode = mode_trace; // RULE5
        end
      end
      mode_trace: begin
        if (trace_done) begin
          nxt_mode = mode_background;
        end
      end
      mode_wait: begin
        if (wait_bg) begin
          nxt_mode = mode_background;
        end else if (irq_wake) begin
          nxt_mode = mode_run;
        end
      end
      mode_stop: begin
        if (irq_wake) begin
          nxt_mode = mode_run;
        end
      end
    endcase
  end

  // ----------------------------------------
  // Answer and fault counter
  // ----------------------------------------
  always_comb begin
    nxt_resp.done = dbg_cmd.valid;
    nxt_resp.accepted = cmd_accept;
    nxt_resp.low_power_err = cmd_lp_err; // RULE10
  end

  always_comb begin
    nxt_fault_cnt = fault_cnt_ff;
    if (run_stop_bad) begin
      nxt_fault_cnt = `FAULT_LEN; // RULE14
    end else if (fault_cnt_ff != `FAULT_CNT_ZERO) begin
      nxt_fault_cnt = fault_cnt_ff - `FAULT_CNT_ONE;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_ff <= mode_run;
      bg_pend_ff <= `BIT_CLR;
      stop_deep_ff <= `BIT_CLR;
      fault_cnt_ff <= `FAULT_CNT_ZERO;
      resp_ff <= '0;
    end else begin
      mode_ff <= nxt_mode;
      bg_pend_ff <= pend_set || (bg_pend_ff && !pend_clr); // RULE15
      stop_deep_ff <= run_stop_ok ? stop_deep_sel : stop_deep_ff; // RULE12
      fault_cnt_ff <= nxt_fault_cnt;
      resp_ff <= nxt_resp;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      imask_clear_ff <= `BIT_CLR;
      stack_start_ff <= `BIT_CLR;
      resume_ff <= `BIT_CLR;
      trace_ff <= `BIT_CLR;
    end else begin
      imask_clear_ff <= run_wait; // RULE7
      stack_start_ff <= irq_wake; // RULE8
      resume_ff <= (mode_ff == mode_background) && (take_go || take_trace); // RULE5
      trace_ff <= (mode_ff == mode_background) && take_trace;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_acc_ff <= `BIT_CLR;
      cpu_reg_ff <= `BIT_CLR;
      dbg_reg_ff <= `BIT_CLR;
    end else begin
      mem_acc_ff <= cmd_access_ok; // RULE10
      cpu_reg_ff <= take_cpu_reg; // RULE4
      dbg_reg_ff <= take_dbg_reg; // RULE3
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign dbg_resp = resp_ff;
  assign cpu_hold = (mode_ff == mode_background); // RULE1
  assign cpu_clk_en = !(in_wait || in_stop); // RULE6
  assign clocks_halted = in_stop; // RULE13
  assign stop_deep = stop_deep_ff;
  assign imask_clear = imask_clear_ff;
  assign stack_start = stack_start_ff;
  assign resume_pulse = resume_ff;
  assign trace_step = trace_ff;
  assign mem_access_en = mem_acc_ff;
  assign cpu_reg_access = cpu_reg_ff;
  assign dbg_reg_access = dbg_reg_ff;
  assign stop_fault_reset = (fault_cnt_ff != `FAULT_CNT_ZERO);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_wait_entry;
    run_wait |=> !cpu_clk_en && imask_clear ##1 !imask_clear;
  endproperty
  a_wait_entry: assert property (p_wait_entry) else $error("wait entry wrong"); // RULE6 RULE7

  property p_irq_wake;
    in_wait && core_evt.irq_req && !(dbg_cmd.valid && dbg_cmd.kind == cmd_background)
      |=> cpu_clk_en && stack_start && !cpu_hold;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("irq wake wrong"); // RULE8

  property p_wait_status_err;
    in_wait && dbg_cmd.valid && dbg_cmd.kind == cmd_mem_status
      |=> dbg_resp.done && dbg_resp.low_power_err && !mem_access_en;
  endproperty
  a_wait_status_err: assert property (p_wait_status_err) else $error("no error in wait"); // RULE10

  property p_wait_reject;
    in_wait && dbg_cmd.valid && (dbg_cmd.kind == cmd_mem || dbg_cmd.kind == cmd_cpu_reg)
      |=> dbg_resp.done && !dbg_resp.accepted && !mem_access_en && !cpu_reg_access;
  endproperty
  a_wait_reject: assert property (p_wait_reject) else $error("wait accepted bad cmd"); // RULE9

  property p_wait_bg;
    in_wait && dbg_cmd.valid && dbg_cmd.kind == cmd_background |=> cpu_hold && cpu_clk_en && !bg_pend_ff;
  endproperty
  a_wait_bg: assert property (p_wait_bg) else $error("wait not woken"); // RULE11

  property p_stop_fault;
    in_run && core_evt.stop_exec && !stop_enable_bit |=> !clocks_halted && stop_fault_reset [*3] ##1 !stop_fault_reset;
  endproperty
  a_stop_fault: assert property (p_stop_fault) else $error("stop fault wrong"); // RULE14

  property p_stop_entry;
    in_run && core_evt.stop_exec && stop_enable_bit |=> clocks_halted && !cpu_clk_en && stop_deep == $past(stop_deep_sel);
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop entry wrong"); // RULE12 RULE13

  property p_bg_boundary;
    in_run && bg_pend_ff && !core_evt.instr_boundary && !core_evt.wait_exec && !core_evt.stop_exec
      |=> !cpu_hold;
  endproperty
  a_bg_boundary: assert property (p_bg_boundary) else $error("entered between instructions"); // RULE15

  property p_run_active_reject;
    in_run && dbg_cmd.valid && dbg_cmd.kind == cmd_cpu_reg |=> !dbg_resp.accepted && !cpu_reg_access;
  endproperty
  a_run_active_reject: assert property (p_run_active_reject) else $error("active cmd in run"); // RULE4

  property p_go;
    cpu_hold && dbg_cmd.valid && dbg_cmd.kind == cmd_go |=> resume_pulse && !cpu_hold;
  endproperty
  a_go: assert property (p_go) else $error("resume failed"); // RULE5

  property p_run_mem;
    in_run && dbg_cmd.valid && dbg_cmd.kind == cmd_mem |=> dbg_resp.accepted && mem_access_en;
  endproperty
  a_run_mem: assert property (p_run_mem) else $error("run mem refused"); // RULE2 RULE3

  property p_trace;
    cpu_hold && dbg_cmd.valid && dbg_cmd.kind == cmd_trace |=> trace_step && resume_pulse && !cpu_hold;
  endproperty
  a_trace: assert property (p_trace) else $error("trace step failed"); // RULE5

  property p_trace_end;
    (mode_ff == mode_trace) && core_evt.instr_boundary |=> cpu_hold && !trace_step;
  endproperty
  a_trace_end: assert property (p_trace_end) else $error("trace did not return"); // RULE1

  property p_stop_wake;
    in_stop && core_evt.irq_req |=> !clocks_halted && cpu_clk_en && stack_start;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop wake wrong"); // RULE13

  property p_stop_reject;
    in_stop && dbg_cmd.valid && dbg_cmd.kind == cmd_background |=> dbg_resp.done && !dbg_resp.accepted && clocks_halted;
  endproperty
  a_stop_reject: assert property (p_stop_reject) else $error("stop accepted bad cmd"); // RULE13

  property p_resp_done;
    dbg_cmd.valid |=> dbg_resp.done;
  endproperty
  a_resp_done: assert property (p_resp_done) else $error("command not answered"); // RULE2

endmodule : mode_ctrl

// File: dv/dbg_host.sv
// Debug host model issuing decoded commands
module dbg_host
  import mode_ctrl_pkg::*;
(
  // Clock
  input wire logic clk,
  // Command to the controller
  output dbg_cmd_t dbg_cmd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial dbg_cmd = '0;

  // One command, valid for one edge
  task automatic send(input cmd_kind_t k);
    @(posedge clk);
    #1 dbg_cmd = '{valid: 1'b1, kind: k};
    @(posedge clk);
    #1 dbg_cmd = '{valid: 1'b0, kind: cmd_kind_t'(~k)};
  endtask : send
endmodule : dbg_host

// File: dv/tb_mode_ctrl.sv
// Testbench for the operating-mode controller
module tb_mode_ctrl
  import mode_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic stop_enable_bit = 1'b0;
  logic stop_deep_sel = 1'b0;
  core_evt_t core_evt = '0;
  dbg_cmd_t dbg_cmd;
  dbg_resp_t dbg_resp;
  logic cpu_hold, cpu_clk_en, clocks_halted, stop_deep, imask_clear, stack_start;
  logic resume_pulse, trace_step, mem_access_en, cpu_reg_access, dbg_reg_access;
  logic stop_fault_reset;
  int n_fail = 0;
  int n_checks = 0;
  wire [7:0] rsp = {dbg_resp, mem_access_en, cpu_reg_access, dbg_reg_access, resume_pulse, trace_step};
  wire [7:0] lv = {5'h0, cpu_hold, cpu_clk_en, clocks_halted};

  always #10 clk = ~clk;

  dbg_host host (.clk(clk), .dbg_cmd(dbg_cmd));

  mode_ctrl DUT (.clk(clk), .reset(reset), .core_evt(core_evt),
    .stop_enable_bit(stop_enable_bit), .stop_deep_sel(stop_deep_sel),
    .dbg_cmd(dbg_cmd), .dbg_resp(dbg_resp), .cpu_hold(cpu_hold),
    .cpu_clk_en(cpu_clk_en), .clocks_halted(clocks_halted),
    .stop_deep(stop_deep), .imask_clear(imask_clear),
    .stack_start(stack_start), .resume_pulse(resume_pulse),
    .trace_step(trace_step), .mem_access_en(mem_access_en),
    .cpu_reg_access(cpu_reg_access), .dbg_reg_access(dbg_reg_access),
    .stop_fault_reset(stop_fault_reset));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic test_done();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic ev(input core_evt_t e);
    @(posedge clk);
    #1 core_evt = e;
    step();
    core_evt = '0;
  endtask : ev

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_run_cmds();
    logic [7:0] e [7] = '{8'hd0, 8'hd0, 8'hc4, 8'hc0, 8'h80, 8'h80, 8'h80};
    for (int i = 0; i < 7; i++) begin
      host.send(cmd_kind_t'(i));
      chk("run_rsp", rsp, e[i]);
      chk("run_lv", lv, 8'h02);
    end
    ev('{instr_boundary: 1'b1, default: 1'b0});
    chk("bg_lv", lv, 8'h06);
  endtask : t_run_cmds

  task automatic t_bg_cmds();
    host.send(cmd_cpu_reg);
    chk("cpu_reg", rsp, 8'hc8);
    host.send(cmd_mem);
    chk("bg_mem", rsp, 8'hd0);
    host.send(cmd_trace);
    chk("trace", rsp, 8'hc3);
    chk("trace_lv", lv, 8'h02);
    ev('{instr_boundary: 1'b1, default: 1'b0});
    chk("trace_end", lv, 8'h06);
    host.send(cmd_go);
    chk("go", rsp, 8'hc2);
    chk("go_lv", lv, 8'h02);
  endtask : t_bg_cmds

  task automatic t_wait();
    logic [7:0] e [7] = '{8'h80, 8'he0, 8'h80, 8'hc0, 8'h80, 8'h80, 8'h80};
    int j;
    host.send(cmd_background);
    chk("pend_rsp", rsp, 8'hc0);
    ev('{wait_exec: 1'b1, default: 1'b0});
    chk("wait_lv", lv, 8'h00);
    chk("imask", {7'h0, imask_clear}, 8'h01);
    for (int i = 0; i < 7; i++) begin
      j = (i + 4) % 7;
      host.send(cmd_kind_t'(j));
      chk("wait_rsp", rsp, e[j]);
    end
    chk("wait_bg", lv, 8'h06);
    host.send(cmd_go);
    ev('{instr_boundary: 1'b1, default: 1'b0});
    chk("stale_pend", lv, 8'h02);
    ev('{wait_exec: 1'b1, default: 1'b0});
    ev('{irq_req: 1'b1, default: 1'b0});
    chk("wake_lv", lv, 8'h02);
    chk("stack", {7'h0, stack_start}, 8'h01);
    step();
    chk("stack_end", {7'h0, stack_start}, 8'h00);
  endtask : t_wait

  task automatic t_stop();
    stop_enable_bit = 1'b1;
    for (int d = 0; d < 2; d++) begin
      stop_deep_sel = d[0];
      ev('{stop_exec: 1'b1, default: 1'b0});
      chk("stop_lv", lv, 8'h01);
      chk("deep", {7'h0, stop_deep}, {7'h0, d[0]});
      host.send(cmd_mem_status);
      chk("stop_ms", rsp, 8'he0);
      host.send(cmd_background);
      chk("stop_bg", rsp, 8'h80);
      ev('{irq_req: 1'b1, default: 1'b0});
      chk("stop_wake", lv, 8'h02);
    end
  endtask : t_stop

  task automatic t_fault();
    stop_enable_bit = 1'b0;
    ev('{stop_exec: 1'b1, default: 1'b0});
    for (int c = 0; c < 4; c++) begin
      chk("fault", {7'h0, stop_fault_reset}, {7'h0, c < 3});
      chk("fault_lv", lv, 8'h02);
      step();
    end
  endtask : t_fault

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    #1 reset = 1'b0;
    chk("reset_lv", lv, 8'h02);
    t_run_cmds();
    t_bg_cmds();
    t_wait();
    t_stop();
    t_fault();
    test_done();
  end

  initial begin
    #100000;
    n_fail++;
    test_done();
  end
endmodule : tb_mode_ctrl
